// ### hdl/spa_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// small byte fifo between serial input and packer
module spa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0] wp_r;            // write pointer
  logic [AW-1:0] rp_r;            // read pointer
  logic [AW:0] cnt_r;             // fill level
  logic [AW:0] cnt_nxt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  // ready is registered so the source sees a flop, not a path
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
    end else begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt < (AW+1)'(DEPTH));
    end
  end
  // data write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule : spa_fifo
////////////////////////////////////////////////////////////////////////
// serial packet aggregator, apb slave, connection supervision
module spa_top #(
  parameter int MS_CYC = spa_pkg::SPA_MS_CYC,
  parameter int MIN_MS = spa_pkg::SPA_MIN_MS,
  parameter int KA_MS = spa_pkg::SPA_KA_MS
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // serial receive bytes
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  output logic RX_READY,
  input wire logic SER_TX_ACT,
  // packet toward network
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_LAST,
  input wire logic TX_READY,
  // connection control
  input wire logic CONN_REQ,
  input wire logic [15:0] CONN_PORT,
  input wire logic NET_ACT,
  input wire logic REMOTE_CLOSE,
  input wire logic KA_ACK,
  output logic CONN_OPEN,
  output logic CONN_CLOSE,
  output logic KA_PROBE
);
  import spa_pkg::*;
  ////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0] d1_r, d2_r;     // delimiter values
  logic d1en_r, d2en_r;       // delimiter enables
  spa_proc_t proc_r;          // post-processing mode
  logic [15:0] force_r;       // force timeout, ms
  logic [10:0] plen_r;        // packing length
  logic [6:0] alive_r;        // network idle, minutes
  logic [15:0] idle_r;        // serial idle, ms
  logic [15:0] lport_r;       // listen port
  // packer state
  spa_state_t st_r;
  logic [10:0] cnt_r;         // bytes buffered
  logic [10:0] len_r;         // bytes to send
  logic [10:0] rd_r;          // drain index
  logic seen1_r;              // last stored byte was delimiter one
  logic [1:0] extra_r;        // bytes still owed after delimiter
  logic [15:0] to_r;          // ms since packet start
  logic [7:0] buf_mem [SPA_BUF_BYTES];
  // fifo drain side
  logic f_valid;
  logic [7:0] f_data;
  ////////////////////////////////////////////////////////////////////
  // apb decode
  wire acc = PSEL && PENABLE && !PREADY;
  // write lands on the edge that completes the transfer
  wire wr = PSEL && PENABLE && PREADY && PWRITE;
  wire hit_dl = (PADDR == SPA_DELIM_OFS);
  wire hit_fo = (PADDR == SPA_FORCE_OFS);
  wire hit_pl = (PADDR == SPA_PLEN_OFS);
  wire hit_al = (PADDR == SPA_ALIVE_OFS);
  wire hit_id = (PADDR == SPA_IDLE_OFS);
  wire hit_po = (PADDR == SPA_PORT_OFS);
  wire hit_st = (PADDR == SPA_STAT_OFS);
  wire mapped = hit_dl | hit_fo | hit_pl | hit_al | hit_id | hit_po
              | hit_st;
  wire [31:0] rd_dl = {12'h000, proc_r, d2en_r, d1en_r, d2_r, d1_r};
  wire [31:0] rd_st = {15'h0000, CONN_OPEN, 5'h00, cnt_r};
  wire [31:0] rd_mux = hit_dl ? rd_dl
                     : hit_fo ? {16'h0000, force_r}
                     : hit_pl ? {21'h000000, plen_r}
                     : hit_al ? {25'h0000000, alive_r}
                     : hit_id ? {16'h0000, idle_r}
                     : hit_po ? {16'h0000, lport_r}
                     : hit_st ? rd_st : 32'h0000_0000;
  // packing length clamps at 1024; network idle wraps to PWDATA[6:0], then clamps at 99
  wire [10:0] plen_w = (PWDATA[31:11] != '0 || PWDATA[10])
                     ? 11'h400 : PWDATA[10:0];
  wire [6:0] alive_w = (PWDATA[6:0] > SPA_ALIVE_MAX)
                     ? SPA_ALIVE_MAX : PWDATA[6:0];
  // one wait state: answer on second access cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= acc;
      PSLVERR <= acc && !mapped;
      PRDATA <= (acc && !PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end
  // register writes
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {d1_r, d2_r, d1en_r, d2en_r} <= 18'h00000;
      proc_r <= SPA_NOTHING;
      force_r <= 16'h0000;
      plen_r <= 11'h000;
      alive_r <= SPA_ALIVE_RST;
      idle_r <= 16'h0000;
      lport_r <= SPA_PORT_RST;
    end else if (wr) begin
      if (hit_dl) begin
        d1_r <= PWDATA[7:0];
        d2_r <= PWDATA[SPA_D2_POS +: 8];
        d1en_r <= PWDATA[SPA_D1EN_POS];
        d2en_r <= PWDATA[SPA_D2EN_POS];
        proc_r <= spa_proc_t'(PWDATA[SPA_PROC_POS +: 2]);
      end
      if (hit_fo) force_r <= PWDATA[15:0];
      if (hit_pl) force_r <= force_r;
      if (hit_pl) plen_r <= plen_w;
      if (hit_al) alive_r <= alive_w;
      if (hit_id) idle_r <= PWDATA[15:0];
      // port zero is not a legal listen port
      if (hit_po && PWDATA[15:0] != 16'h0000) lport_r <= PWDATA[15:0];
    end
  end
  ////////////////////////////////////////////////////////////////////
  // input fifo; stalls while a packet drains
  wire take = f_valid && (st_r == SPA_COLLECT);
  spa_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
    .clk(CLK),
    .reset_n(RESET_N),
    .in_valid(RX_VALID),
    .in_data(RX_DATA),
    .in_ready(RX_READY),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(st_r == SPA_COLLECT)
  );
  ////////////////////////////////////////////////////////////////////
  // millisecond tick from the clock divider
  logic [15:0] div_r;
  wire ms_tick = (div_r == 16'(MS_CYC - 1));
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) div_r <= 16'h0000;
    else div_r <= ms_tick ? 16'h0000 : div_r + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////////
  // flush decisions
  wire is_d1 = d1en_r && (f_data == d1_r);
  wire is_d2 = d2en_r && (f_data == d2_r);
  // only delimiter two set gives no detection at all
  wire delim_hit = (extra_r == 2'h0) && d1en_r
                 && (d2en_r ? (seen1_r && is_d2) : is_d1);
  wire strip = delim_hit && (proc_r == SPA_STRIP);
  wire plus = delim_hit && (proc_r == SPA_PLUS1 || proc_r == SPA_PLUS2);
  wire [10:0] cnt_inc = cnt_r + 11'h001;
  wire extra_done = (extra_r == 2'h1);
  wire plen_hit = (plen_r != 11'h000) && (cnt_inc == plen_r);
  wire full_hit = (cnt_r == SPA_BUF_LAST);
  wire to_hit = (force_r != 16'h0000) && (cnt_r != 11'h000)
              && (to_r >= force_r);
  wire store_fl = take && !strip
                && ((delim_hit && !plus) || extra_done || plen_hit
                    || full_hit);
  wire strip_fl = take && strip;
  // strip removes the already stored first delimiter too
  wire [10:0] strip_len = cnt_r - {10'h000, d2en_r};
  wire flush = store_fl || strip_fl || (!take && to_hit
               && st_r == SPA_COLLECT);
  wire [10:0] flush_len = strip_fl ? strip_len
                        : store_fl ? cnt_inc : cnt_r;
  wire tx_adv = !TX_VALID || TX_READY;
  wire tx_end = (rd_r == len_r);
  ////////////////////////////////////////////////////////////////////
  // buffer write
  always_ff @(posedge CLK) begin
    if (take && !strip) buf_mem[cnt_r[9:0]] <= f_data;
  end
  // packer state and counters
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= SPA_COLLECT;
      cnt_r <= 11'h000;
      len_r <= 11'h000;
      seen1_r <= 1'b0;
      extra_r <= 2'h0;
      to_r <= 16'h0000;
    end else if (st_r == SPA_COLLECT) begin
      if (flush) begin
        // every cause restarts all packing counters
        cnt_r <= 11'h000;
        seen1_r <= 1'b0;
        extra_r <= 2'h0;
        to_r <= 16'h0000;
        len_r <= flush_len;
        st_r <= (flush_len == 11'h000) ? SPA_COLLECT : SPA_DRAIN;
      end else if (take) begin
        cnt_r <= cnt_inc;
        seen1_r <= is_d1;
        if (plus) extra_r <= (proc_r == SPA_PLUS1) ? 2'h1 : 2'h2;
        else if (extra_r != 2'h0) extra_r <= extra_r - 2'h1;
        if (cnt_r == 11'h000) to_r <= 16'h0000;
        else if (ms_tick) to_r <= to_r + 16'h0001;
      end else if (ms_tick && cnt_r != 11'h000) begin
        to_r <= to_r + 16'h0001;
      end
    end else if (tx_adv && tx_end) begin
      st_r <= SPA_COLLECT;
    end
  end
  // drain to network, one byte per accepted beat
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_r <= 11'h000;
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
      TX_LAST <= 1'b0;
    end else if (st_r == SPA_COLLECT) begin
      rd_r <= 11'h000;
      if (TX_READY) TX_VALID <= 1'b0;
    end else if (tx_adv) begin
      TX_VALID <= !tx_end;
      TX_DATA <= buf_mem[rd_r[9:0]];
      TX_LAST <= (rd_r + 11'h001 == len_r);
      if (!tx_end) rd_r <= rd_r + 11'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // connection supervision
  logic [15:0] idle_cnt_r;    // ms since serial activity
  logic [15:0] net_ms_r;      // ms within current minute
  logic [6:0] net_min_r;      // idle minutes on network
  logic [15:0] ka_cnt_r;      // ms since last probe
  logic ka_wait_r;            // probe sent, no answer yet
  wire ser_act = take || SER_TX_ACT;
  wire idle_exp = (idle_r != 16'h0000) && (idle_cnt_r == idle_r);
  wire alive_exp = (alive_r != 7'h00) && (net_min_r == alive_r);
  wire ka_due = ms_tick && (ka_cnt_r == 16'(KA_MS - 1));
  wire ka_fail = ka_due && ka_wait_r && !KA_ACK;
  wire accept = !CONN_OPEN && CONN_REQ && (CONN_PORT == lport_r);
  // zero idle setting leaves only remote close, network idle and probes
  wire close_now = CONN_OPEN && (REMOTE_CLOSE || idle_exp
                 || alive_exp || ka_fail);
  wire min_tick = ms_tick && (net_ms_r == 16'(MIN_MS - 1));
  // open/listen state; closing returns to listen
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CONN_OPEN <= 1'b0;
      CONN_CLOSE <= 1'b0;
    end else begin
      CONN_CLOSE <= close_now;
      if (close_now) CONN_OPEN <= 1'b0;
      else if (accept) CONN_OPEN <= 1'b1;
    end
  end
  // idle timers restart on activity or new connection
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      idle_cnt_r <= 16'h0000;
      net_ms_r <= 16'h0000;
      net_min_r <= 7'h00;
    end else begin
      if (!CONN_OPEN || ser_act) idle_cnt_r <= 16'h0000;
      else if (ms_tick && !idle_exp) idle_cnt_r <= idle_cnt_r + 16'h0001;
      if (!CONN_OPEN || NET_ACT) begin
        net_ms_r <= 16'h0000;
        net_min_r <= 7'h00;
      end else if (ms_tick) begin
        net_ms_r <= min_tick ? 16'h0000 : net_ms_r + 16'h0001;
        if (min_tick && !alive_exp) net_min_r <= net_min_r + 7'h01;
      end
    end
  end
  // keep-alive probes; a new probe wins over a same-cycle answer
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ka_cnt_r <= 16'h0000;
      ka_wait_r <= 1'b0;
      KA_PROBE <= 1'b0;
    end else begin
      KA_PROBE <= CONN_OPEN && ka_due && !ka_fail;
      if (!CONN_OPEN) begin
        ka_cnt_r <= 16'h0000;
        ka_wait_r <= 1'b0;
      end else begin
        if (ms_tick) ka_cnt_r <= ka_due ? 16'h0000 : ka_cnt_r + 16'h0001;
        if (ka_due) ka_wait_r <= 1'b1;
        else if (KA_ACK) ka_wait_r <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_pair_flush: assert property (take && d1en_r && d2en_r && seen1_r
    && is_d2 && extra_r == 2'h0 && proc_r == SPA_NOTHING
    |=> st_r == SPA_DRAIN && len_r == $past(cnt_r) + 11'h001)
    else $error("pair of delimiters did not flush");
  a_single_flush: assert property (take && d1en_r && !d2en_r
    && is_d1 && extra_r == 2'h0 && proc_r == SPA_NOTHING
    |=> st_r == SPA_DRAIN)
    else $error("single delimiter did not flush");
  a_full_flush: assert property (take && cnt_r == SPA_BUF_LAST
    |=> st_r == SPA_DRAIN && cnt_r == 11'h000)
    else $error("full buffer did not flush");
  a_plus_wait: assert property (take && plus && !plen_hit && !full_hit
    |=> st_r == SPA_COLLECT && extra_r != 2'h0)
    else $error("plus mode flushed too early");
  a_strip_len: assert property (take && strip && !d2en_r
    && cnt_r != 11'h000 |=> len_r == $past(cnt_r))
    else $error("strip mode length wrong");
  a_to_off: assert property (!f_valid && force_r == 16'h0000
    && st_r == SPA_COLLECT |=> st_r == SPA_COLLECT)
    else $error("timeout fired while disabled");
  a_plen_flush: assert property (take && plen_hit
    |=> st_r == SPA_DRAIN ##0 len_r == plen_r)
    else $error("packing length did not flush");
  a_port_match: assert property (!CONN_OPEN && CONN_REQ
    && CONN_PORT != lport_r |=> !CONN_OPEN)
    else $error("connection on wrong port");
  a_ka_close: assert property (CONN_OPEN && ka_fail
    |=> !CONN_OPEN && CONN_CLOSE)
    else $error("lost probe did not close");
  a_idle_keep: assert property (CONN_OPEN && idle_r == 16'h0000
    && !REMOTE_CLOSE && !alive_exp && !ka_fail |=> CONN_OPEN)
    else $error("connection closed without cause");
  c_delim: cover property (st_r == SPA_COLLECT && flush && delim_hit);
  c_timeout: cover property (st_r == SPA_COLLECT && to_hit ##1 TX_VALID);
  c_close: cover property (CONN_OPEN ##1 CONN_CLOSE);
endmodule : spa_top
`default_nettype wire

// ### include/spa_pkg.sv
// Function
// - both delimiters in sequence flush the buffer
// - without second delimiter, first alone flushes
// - full 1 KB buffer flushes automatically
// - plus-one/plus-two modes wait for extra bytes
// - strip mode drops delimiter bytes from packet
// - do-nothing mode sends delimiter with data
// - force timeout 0..65535 ms, zero disables
// - nonzero timeout groups bytes, flushes on expiry
// - packing length 0..1024, nonzero count forces flush
// - network idle timer 0..99 min, closes connection
// - serial idle timer 0..65535 ms, closes connection
// - serial idle zero keeps connection until remote close, network idle or lost probe
// - periodic keep-alive probes, no answer closes
// - listen port 1..65535, default 4001
`default_nettype none
package spa_pkg;
  // register byte offsets
  localparam logic [7:0] SPA_DELIM_OFS = 8'h00;
  localparam logic [7:0] SPA_FORCE_OFS = 8'h04;
  localparam logic [7:0] SPA_PLEN_OFS = 8'h08;
  localparam logic [7:0] SPA_ALIVE_OFS = 8'h0C;
  localparam logic [7:0] SPA_IDLE_OFS = 8'h10;
  localparam logic [7:0] SPA_PORT_OFS = 8'h14;
  localparam logic [7:0] SPA_STAT_OFS = 8'h18;
  // delimiter and status register field positions
  localparam int SPA_D2_POS = 8;
  localparam int SPA_D1EN_POS = 16;
  localparam int SPA_D2EN_POS = 17;
  localparam int SPA_PROC_POS = 18;
  localparam int SPA_OPEN_POS = 16;
  // reset values and limits
  localparam logic [6:0] SPA_ALIVE_RST = 7'h07;
  localparam logic [6:0] SPA_ALIVE_MAX = 7'h63;
  localparam logic [15:0] SPA_PORT_RST = 16'h0FA1;
  // buffer size, bytes
  localparam int SPA_BUF_BYTES = 1024;
  localparam logic [10:0] SPA_BUF_LAST = 11'h3FF;
  // timing: clock rate and derived counts
  localparam int SPA_CLK_HZ = 40000000;
  localparam int SPA_MS_PER_S = 1000;
  localparam int SPA_MS_CYC = SPA_CLK_HZ / SPA_MS_PER_S;
  localparam int SPA_MIN_MS = 60000;
  localparam int SPA_KA_MS = 1000;
  // delimiter post-processing
  typedef enum logic [1:0] {
    SPA_NOTHING = 2'h0,
    SPA_PLUS1 = 2'h1,
    SPA_PLUS2 = 2'h2,
    SPA_STRIP = 2'h3
  } spa_proc_t;
  // packer states, gray along collect-drain
  typedef enum logic [0:0] {
    SPA_COLLECT = 1'b0,
    SPA_DRAIN = 1'b1
  } spa_state_t;
endpackage : spa_pkg
`default_nettype wire

// ### testbench/spa_far_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// serial device feeding bytes, network stack taking packets
module spa_far_model (
  // clock
  input wire logic CLK,
  // serial device side
  output logic RX_VALID,
  output logic [7:0] RX_DATA,
  input wire logic RX_READY,
  // network stack side
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST,
  output logic TX_READY,
  input wire logic KA_PROBE,
  output logic KA_ACK
);
  logic stall = 1'b0; // network side holds off
  logic ka_on = 1'b1; // remote answers keep-alive probes
  logic [7:0] got[$]; // bytes of packets not yet checked
  int pkts = 0; // packets ended by a last beat
  int stuck = 0; // bytes never accepted within the bound
  initial begin
    RX_VALID = 1'b0;
    RX_DATA = 8'h00;
    TX_READY = 1'b0;
    KA_ACK = 1'b0;
  end
  // burst held back to back; a byte not taken within 5000 cycles counts as stuck
  task automatic send_q(input logic [7:0] q[$]);
    int i;
    @(posedge CLK);
    foreach (q[k]) begin
      RX_VALID <= 1'b1;
      RX_DATA <= q[k];
      for (i = 0; i < 5000; i++) begin
        @(posedge CLK);
        if (RX_READY === 1'b1) break;
      end
      if (i == 5000) stuck++;
    end
    RX_VALID <= 1'b0;
    // stale byte inverted so it can never pass for fresh data
    RX_DATA <= ~RX_DATA;
  endtask : send_q
  // sink beats unless stalled; probe answer one cycle late
  always @(posedge CLK) begin
    TX_READY <= ~stall;
    KA_ACK <= KA_PROBE & ka_on;
    if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
      got.push_back(TX_DATA);
      if (TX_LAST === 1'b1) pkts++;
    end
  end
endmodule : spa_far_model
`default_nettype wire

// ### testbench/tb_serial_packet_aggregator.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
////////////////////////////////////////////////////////////////////////
// scenarios for the packet aggregator, each judging its own result
module tb_serial_packet_aggregator;
  import spa_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, rx_valid, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic conn_req = 1'b0, remote_close = 1'b0, ka_ack;
  logic ser_tx_act = 1'b0, net_act = 1'b0;
  logic [15:0] conn_port = 16'h0000;
  logic conn_open, conn_close, ka_probe;
  int error_cnt = 0, compares = 0, want = 0, closes = 0;
  logic [7:0] q[$];
  always #12.5 clk = ~clk;
  // short ms, minute and probe counts keep the run brief
  spa_top #(.MS_CYC(4), .MIN_MS(3), .KA_MS(5)) dut (.CLK(clk),
    .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_READY(rx_ready), .SER_TX_ACT(ser_tx_act), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_LAST(tx_last), .TX_READY(tx_ready),
    .CONN_REQ(conn_req), .CONN_PORT(conn_port), .NET_ACT(net_act),
    .REMOTE_CLOSE(remote_close), .KA_ACK(ka_ack), .CONN_OPEN(conn_open),
    .CONN_CLOSE(conn_close), .KA_PROBE(ka_probe));
  spa_far_model far (.CLK(clk), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_LAST(tx_last), .TX_READY(tx_ready), .KA_PROBE(ka_probe),
    .KA_ACK(ka_ack));
  // close pulses counted for the final tally
  always @(posedge clk) if (conn_close === 1'b1) closes++;
  task automatic conclude;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic hang;
    error_cnt++;
    conclude();
  endtask : hang
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask : rd_chk
  // next packet compared whole, length and last marker included
  task automatic expect_pkt(input logic [7:0] x[$]);
    int i;
    for (i = 0; i < 3000 && far.pkts <= want; i++) @(negedge clk);
    if (i == 3000) hang();
    want++;
    `CHK(far.got.size(), x.size())
    foreach (x[k]) `CHK(far.got[k], x[k])
    far.got.delete();
  endtask : expect_pkt
  task automatic t_regs;
    rd_chk(SPA_FORCE_OFS, 32'h0, 1'b0);
    rd_chk(SPA_PLEN_OFS, 32'h0, 1'b0);
    rd_chk(SPA_ALIVE_OFS, 32'h7, 1'b0);
    rd_chk(SPA_IDLE_OFS, 32'h0, 1'b0);
    rd_chk(SPA_PORT_OFS, 32'hFA1, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
    wr(SPA_PORT_OFS, 32'h0);
    rd_chk(SPA_PORT_OFS, 32'hFA1, 1'b0);
    wr(SPA_PLEN_OFS, 32'h7D0);
    rd_chk(SPA_PLEN_OFS, 32'h400, 1'b0);
    wr(SPA_ALIVE_OFS, 32'h70);
    rd_chk(SPA_ALIVE_OFS, 32'h63, 1'b0);
    wr(SPA_PLEN_OFS, 32'h0);
  endtask : t_regs
  // first delimiter always enabled before use
  task automatic t_delim;
    wr(SPA_DELIM_OFS, {12'h0, SPA_NOTHING, 2'b01, 8'h0A, 8'h0D});
    far.send_q('{8'h41, 8'h42, 8'h0D});
    expect_pkt('{8'h41, 8'h42, 8'h0D});
    wr(SPA_DELIM_OFS, {12'h0, SPA_NOTHING, 2'b11, 8'h0A, 8'h0D});
    far.send_q('{8'h41, 8'h0D, 8'h0A});
    expect_pkt('{8'h41, 8'h0D, 8'h0A});
    wr(SPA_DELIM_OFS, {12'h0, SPA_STRIP, 2'b01, 8'h0A, 8'h0D});
    far.send_q('{8'h41, 8'h42, 8'h0D});
    expect_pkt('{8'h41, 8'h42});
    // lone first delimiter mid-packet must not flush
    wr(SPA_DELIM_OFS, {12'h0, SPA_STRIP, 2'b11, 8'h0A, 8'h0D});
    far.send_q('{8'h41, 8'h0D, 8'h42, 8'h0D, 8'h0A});
    expect_pkt('{8'h41, 8'h0D, 8'h42});
    wr(SPA_DELIM_OFS, {12'h0, SPA_PLUS1, 2'b01, 8'h0A, 8'h0D});
    far.send_q('{8'h41, 8'h0D, 8'h43});
    expect_pkt('{8'h41, 8'h0D, 8'h43});
    wr(SPA_DELIM_OFS, {12'h0, SPA_PLUS2, 2'b01, 8'h0A, 8'h0D});
    far.send_q('{8'h41, 8'h0D, 8'h43, 8'h44});
    expect_pkt('{8'h41, 8'h0D, 8'h43, 8'h44});
    wr(SPA_DELIM_OFS, 32'h0);
  endtask : t_delim
  task automatic t_len;
    wr(SPA_PLEN_OFS, 32'h3);
    far.send_q('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
    expect_pkt('{8'h01, 8'h02, 8'h03});
    expect_pkt('{8'h04, 8'h05, 8'h06});
    // no trigger armed: byte must wait in the buffer
    wr(SPA_PLEN_OFS, 32'h0);
    far.send_q('{8'h60});
    repeat (100) @(posedge clk);
    `CHK(far.pkts, want)
    rd_chk(SPA_STAT_OFS, 32'h1, 1'b0);
    wr(SPA_PLEN_OFS, 32'h2);
    far.send_q('{8'h61});
    expect_pkt('{8'h60, 8'h61});
    wr(SPA_PLEN_OFS, 32'h0);
  endtask : t_len
  // full buffer drains into a stalled network, input must back up
  task automatic t_full;
    q.delete();
    for (int k = 0; k < 1024; k++) q.push_back(k[7:0]);
    far.stall = 1'b1;
    far.send_q(q);
    far.send_q('{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6, 8'hF7});
    repeat (10) @(negedge clk);
    `CHK(rx_ready, 1'b0)
    `CHK(tx_valid, 1'b1)
    far.stall = 1'b0;
    expect_pkt(q);
    wr(SPA_FORCE_OFS, 32'h2);
    expect_pkt('{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6,
      8'hF7});
    far.send_q('{8'h51, 8'h52});
    expect_pkt('{8'h51, 8'h52});
    wr(SPA_FORCE_OFS, 32'h0);
  endtask : t_full
  task automatic open_conn(input logic [15:0] p);
    @(posedge clk);
    conn_req <= 1'b1;
    conn_port <= p;
    @(posedge clk);
    conn_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : open_conn
  // cycles until the link drops, bounded
  task automatic wait_close(input int lo);
    int n;
    for (n = 0; n < 300 && conn_open !== 1'b0; n++) @(negedge clk);
    `CHK(n >= lo && n < 300, 1'b1)
    if (n == 300) hang();
  endtask : wait_close
  task automatic t_conn;
    wr(SPA_ALIVE_OFS, 32'h0);
    open_conn(16'h0FA2);
    `CHK(conn_open, 1'b0)
    open_conn(16'h0FA1);
    `CHK(conn_open, 1'b1)
    rd_chk(SPA_STAT_OFS, 32'h10000, 1'b0);
    repeat (200) @(posedge clk);
    `CHK(conn_open, 1'b1)
    remote_close <= 1'b1;
    @(posedge clk);
    remote_close <= 1'b0;
    wait_close(0);
    far.ka_on = 1'b0;
    open_conn(16'h0FA1);
    wait_close(10);
    far.ka_on = 1'b1;
    wr(SPA_IDLE_OFS, 32'h3);
    // serial activity holds the link open until it stops
    ser_tx_act <= 1'b1;
    open_conn(16'h0FA1);
    repeat (40) @(posedge clk);
    `CHK(conn_open, 1'b1)
    ser_tx_act <= 1'b0;
    wait_close(5);
    wr(SPA_IDLE_OFS, 32'h0);
    wr(SPA_ALIVE_OFS, 32'h1);
    // network activity restarts the idle minutes
    net_act <= 1'b1;
    open_conn(16'h0FA1);
    repeat (40) @(posedge clk);
    `CHK(conn_open, 1'b1)
    net_act <= 1'b0;
    wait_close(5);
    repeat (3) @(posedge clk);
    `CHK(closes, 4)
  endtask : t_conn
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_delim();
    t_len();
    t_full();
    t_conn();
    `CHK(far.stuck, 0)
    conclude();
  end
endmodule : tb_serial_packet_aggregator
`default_nettype wire
